/* design/phy_vendor_pkg.sv */
// Purpose: Shared constants and types for the PHY vendor mode and interrupt register bank
// Assumes: 16-bit management registers reached by a 5-bit index
// Notes: Every offset, field position, reset value and timing count lives here
`default_nettype none
package phy_vendor_pkg;

    // Register indices
    localparam logic [4:0] IDX_ENERGY_MODE = 5'h11;
    localparam logic [4:0] IDX_STRAP_MODE = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_CTRL = 5'h1B;
    localparam logic [4:0] IDX_IRQ_SOURCE = 5'h1D;
    localparam logic [4:0] IDX_IRQ_MASK = 5'h1E;

    // Field positions
    localparam int EDPD_BIT = 13;
    localparam int ENERGY_BIT = 1;
    localparam int MODE_LSB = 5;
    localparam int PLL_FORCE_BIT = 10;
    localparam int POLARITY_BIT = 4;
    localparam int IRQ_ENERGY_BIT = 7;
    localparam int IRQ_AN_DONE_BIT = 6;
    localparam int IRQ_RFAULT_BIT = 5;
    localparam int IRQ_LINK_BIT = 4;
    localparam int IRQ_ACK_BIT = 3;
    localparam int IRQ_PDF_BIT = 2;
    localparam int IRQ_PAGE_BIT = 1;

    // Reset values and fixed read patterns
    localparam logic [4:0] PHY_ADDR_RESET = 5'h01;
    localparam logic [3:0] SPECIAL_LOW_BITS = 4'hB;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // Mode codes
    localparam logic [2:0] MODE_10_HALF = 3'h0;
    localparam logic [2:0] MODE_10_FULL = 3'h1;
    localparam logic [2:0] MODE_100_HALF = 3'h2;
    localparam logic [2:0] MODE_100_FULL = 3'h3;
    localparam logic [2:0] MODE_AN_100_HALF = 3'h4;
    localparam logic [2:0] MODE_REPEATER = 3'h5;
    localparam logic [2:0] MODE_RESERVED = 3'h6;
    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7;

    // Energy window: time as printed, cycle count derived from the 200 MHz clock
    localparam int CLK_KHZ = 200000;
    localparam int ENERGY_WINDOW_MS = 256;
    localparam int ENERGY_WINDOW_CYCLES = ENERGY_WINDOW_MS * CLK_KHZ;
    localparam int ENERGY_CNT_W = 26;

    // Auto-negotiation events, one-cycle pulses from logic on this clock
    typedef struct packed {
        logic done;
        logic remote_fault;
        logic partner_ack;
        logic parallel_fault;
        logic page_received;
    } an_events_t;

    // Default configuration that the selected mode hands to the rest of the PHY
    typedef struct packed {
        logic [3:0] ctrl_defaults;   // Control reg bits [13,12,10,8]
        logic [3:0] advert_defaults; // Advertisement bits [8,7,6,5]
        logic autoneg_en;
        logic crs_on_tx;
        logic repeater;
        logic full_duplex;
    } mode_cfg_t;

    // Management register request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] index;
        logic [15:0] wdata;
    } mgmt_req_t;

endpackage
`default_nettype wire

/* design/energy_window.sv */
// Purpose: Energy-present indicator with a no-energy timeout window
// Assumes: energy_seen is already synchronised to sys_clk
// Notes: Only the hardware reset touches this state, so it survives a soft reset
`default_nettype none
module energy_window #(
    parameter int WINDOW_CYCLES = phy_vendor_pkg::ENERGY_WINDOW_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Line energy
    input wire logic energy_seen,
    output logic energy_present,
    output logic energy_rise
);
    import phy_vendor_pkg::*;

    localparam logic [ENERGY_CNT_W-1:0] LAST_CNT = ENERGY_CNT_W'(WINDOW_CYCLES - 1);

    logic [ENERGY_CNT_W-1:0] quiet_cnt;

    // Count cycles without energy; any energy restarts the window
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            quiet_cnt <= '0;
        else if (clk_en)
        begin
            if (energy_seen)
                quiet_cnt <= '0;
            else if (quiet_cnt != LAST_CNT)
                quiet_cnt <= quiet_cnt + ENERGY_CNT_W'(1);
        end
    end

    // Indicator is one out of hardware reset and falls after a full quiet window
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            energy_present <= 1'b1;
        else if (clk_en)
        begin
            if (energy_seen)
                energy_present <= 1'b1;
            else if (quiet_cnt == LAST_CNT)
                energy_present <= 1'b0;
        end
    end

    // One-cycle pulse when energy returns after having been absent
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            energy_rise <= 1'b0;
        else if (clk_en)
            energy_rise <= energy_seen && !energy_present;
    end

endmodule
`default_nettype wire

/* design/phy_vendor_regs.sv */
// Purpose: Vendor mode, energy, special control and interrupt registers of a 10/100 PHY
// Assumes: Management port runs on sys_clk; line indications arrive asynchronously
// Notes: Reads answer one cycle after the strobe; soft reset spares the kept fields
//
// Overview of operation
// - Bit 13 enables energy-detect power-down, resets zero
// - Energy-present falls after 256 ms without energy
// - Energy-present set by hardware reset, kept on soft
// - Mode in bits 7:5, address 4:0 default 1
// - Modes 000/001: 10 Mb half/full, no autoneg
// - Modes 010/011: 100 Mb half/full, CRS per duplex
// - Mode 100: autoneg, advertise 100 half only
// - Mode 101: repeater, CRS only on receive
// - Mode 111: autoneg advertising all abilities
// - Bit 10 forces 10 Mb receive PLL to reference
// - Bit 4 reports 10BASE-T receive polarity reversed
// - Special bits 3:0 read 1011, ignore writes
// - Source flags for energy, autoneg, fault, ack, pages
// - Link-lost flag; all flags latch high until read
// - Mask bits 7:0 enable sources, default zero
`default_nettype none
module phy_vendor_regs #(
    parameter int ENERGY_WINDOW = phy_vendor_pkg::ENERGY_WINDOW_CYCLES
) (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic soft_rst,
    // Management register port
    input wire phy_vendor_pkg::mgmt_req_t mgmt_req,
    output logic [15:0] reg_rdata,
    output logic reg_rd_valid,
    // Management frame address match
    input wire logic [4:0] frame_phy_address,
    output logic phy_address_match,
    // Strap and line indications
    input wire logic [2:0] mode_strap,
    input wire logic line_energy,
    input wire logic line_polarity_reversed,
    // Link and auto-negotiation events from this clock
    input wire logic link_status,
    input wire phy_vendor_pkg::an_events_t an_events,
    // Configuration and status outputs
    output phy_vendor_pkg::mode_cfg_t mode_cfg,
    output logic [2:0] op_mode,
    output logic [4:0] mgmt_phy_address,
    output logic energy_detect_powerdown_en,
    output logic energy_present,
    output logic rx_pll_force_reference,
    output logic phy_irq
);
    import phy_vendor_pkg::*;

    // Strap capture sequence
    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN = 2'b10
    } boot_state_t;

    boot_state_t boot_state;
    logic [2:0] energy_sync;
    logic [2:0] polarity_sync;
    logic energy_seen;
    logic rx_polarity_reversed;
    logic energy_rise;
    logic link_prev;
    logic [7:0] irq_flags;
    logic [7:0] irq_mask;
    logic [7:0] next_irq_flags;
    logic [7:0] irq_events;
    logic [15:0] next_rdata;
    logic wr_en;
    logic rd_en;

    // Default configuration that a mode code selects
    function automatic mode_cfg_t decode_mode(input logic [2:0] code);
        mode_cfg_t cfg;
        cfg = '0;
        unique case (code)
            MODE_10_HALF:
                cfg.ctrl_defaults = 4'h0;
            MODE_10_FULL:
            begin
                cfg.ctrl_defaults = 4'h1;
                cfg.full_duplex = 1'b1;
            end
            MODE_100_HALF:
            begin
                cfg.ctrl_defaults = 4'h8;
                cfg.crs_on_tx = 1'b1;
            end
            MODE_100_FULL:
            begin
                cfg.ctrl_defaults = 4'h9;
                cfg.full_duplex = 1'b1;
            end
            MODE_AN_100_HALF:
            begin
                cfg.ctrl_defaults = 4'hC;
                cfg.advert_defaults = 4'h4;
                cfg.autoneg_en = 1'b1;
                cfg.crs_on_tx = 1'b1;
            end
            MODE_REPEATER:
            begin
                cfg.ctrl_defaults = 4'hC;
                cfg.advert_defaults = 4'h4;
                cfg.autoneg_en = 1'b1;
                cfg.repeater = 1'b1;
            end
            MODE_ALL_CAPABLE:
            begin
                cfg.ctrl_defaults = 4'h4;
                cfg.advert_defaults = 4'hF;
                cfg.autoneg_en = 1'b1;
                cfg.full_duplex = 1'b1;
            end
            default:
                cfg = '0; // Reserved code gives an inert configuration
        endcase
        return cfg;
    endfunction

    // Register access is frozen together with everything else
    assign wr_en = clk_en && mgmt_req.wr;
    assign rd_en = clk_en && mgmt_req.rd;

    // Line inputs pass three flops; a change counts once the last two agree
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {energy_sync, polarity_sync} <= 6'h00;
        else if (clk_en)
        begin
            energy_sync <= {energy_sync[1:0], line_energy};
            polarity_sync <= {polarity_sync[1:0], line_polarity_reversed};
        end
    end

    // Filtered levels hold their value while the last two stages disagree
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {energy_seen, rx_polarity_reversed} <= 2'b00;
        else if (clk_en)
        begin
            if (energy_sync[1] == energy_sync[2])
                energy_seen <= energy_sync[2];
            if (polarity_sync[1] == polarity_sync[2])
                rx_polarity_reversed <= polarity_sync[2];
        end
    end

    // Energy indicator and its no-energy window
    energy_window #(
        .WINDOW_CYCLES(ENERGY_WINDOW)
    ) u_energy (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .energy_seen(energy_seen),
        .energy_present(energy_present),
        .energy_rise(energy_rise)
    );

    // Mode strap is sampled on the first enabled edge after reset release
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            boot_state <= ST_STRAP;
        else if (clk_en)
        begin
            unique case (boot_state)
                ST_STRAP, ST_RUN:
                    boot_state <= ST_RUN;
                default:
                    boot_state <= ST_STRAP;
            endcase
        end
    end

    // Mode and address survive a soft reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {op_mode, mgmt_phy_address} <= {MODE_10_HALF, PHY_ADDR_RESET};
        else if (clk_en)
        begin
            if (boot_state == ST_STRAP)
                op_mode <= mode_strap;
            else if (wr_en && mgmt_req.index == IDX_STRAP_MODE)
            begin
                op_mode <= mgmt_req.wdata[MODE_LSB +: 3];
                mgmt_phy_address <= mgmt_req.wdata[4:0];
            end
        end
    end

    // Registered decode keeps the configuration on flops
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_cfg <= '0;
        else if (clk_en)
            mode_cfg <= decode_mode(op_mode);
    end

    // Address comparison with the frame under decode
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            phy_address_match <= 1'b0;
        else if (clk_en)
            phy_address_match <= (frame_phy_address == mgmt_phy_address);
    end

    // PLL force is kept over a soft reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_pll_force_reference <= 1'b0;
        else if (wr_en && mgmt_req.index == IDX_SPECIAL_CTRL)
            rx_pll_force_reference <= mgmt_req.wdata[PLL_FORCE_BIT];
    end

    // Power-down enable and mask return to defaults on soft reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {energy_detect_powerdown_en, irq_mask} <= {1'b0, IRQ_RESET};
        else if (clk_en)
        begin
            if (soft_rst)
                {energy_detect_powerdown_en, irq_mask} <= {1'b0, IRQ_RESET};
            else if (wr_en && mgmt_req.index == IDX_ENERGY_MODE)
                energy_detect_powerdown_en <= mgmt_req.wdata[EDPD_BIT];
            else if (wr_en && mgmt_req.index == IDX_IRQ_MASK)
                irq_mask <= mgmt_req.wdata[7:0];
        end
    end

    // Link-down edge; link_status is produced on this clock so needs no sync
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            link_prev <= 1'b0;
        else if (clk_en)
            link_prev <= link_status;
    end

    // Source events gathered into flag positions
    always_comb
    begin
        irq_events = 8'h00;
        irq_events[IRQ_ENERGY_BIT] = energy_rise;
        irq_events[IRQ_AN_DONE_BIT] = an_events.done;
        irq_events[IRQ_RFAULT_BIT] = an_events.remote_fault;
        irq_events[IRQ_LINK_BIT] = link_prev && !link_status;
        irq_events[IRQ_ACK_BIT] = an_events.partner_ack;
        irq_events[IRQ_PDF_BIT] = an_events.parallel_fault;
        irq_events[IRQ_PAGE_BIT] = an_events.page_received;
    end

    // Reading the source register clears it, but an event in that cycle still lands
    always_comb
    begin
        next_irq_flags = irq_flags;
        if (rd_en && mgmt_req.index == IDX_IRQ_SOURCE)
            next_irq_flags = IRQ_RESET;
        next_irq_flags = next_irq_flags | irq_events;
    end

    // Latched flags; soft reset clears them, keeping only events of that cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_flags <= IRQ_RESET;
        else if (clk_en)
        begin
            if (soft_rst)
                irq_flags <= irq_events;
            else
                irq_flags <= next_irq_flags;
        end
    end

    // Request level from the flags that will stand after this edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            phy_irq <= 1'b0;
        else if (clk_en)
            phy_irq <= !soft_rst && |(next_irq_flags & irq_mask);
    end

    // Read multiplexer; reserved bits and unmapped indices read zero
    always_comb
    begin
        next_rdata = ZERO_WORD;
        unique case (mgmt_req.index)
            IDX_ENERGY_MODE:
            begin
                next_rdata[EDPD_BIT] = energy_detect_powerdown_en;
                next_rdata[ENERGY_BIT] = energy_present;
            end
            IDX_STRAP_MODE:
            begin
                next_rdata[MODE_LSB +: 3] = op_mode;
                next_rdata[4:0] = mgmt_phy_address;
            end
            IDX_SPECIAL_CTRL:
            begin
                next_rdata[PLL_FORCE_BIT] = rx_pll_force_reference;
                next_rdata[POLARITY_BIT] = rx_polarity_reversed;
                next_rdata[3:0] = SPECIAL_LOW_BITS;
            end
            IDX_IRQ_SOURCE:
                next_rdata[7:0] = irq_flags;
            IDX_IRQ_MASK:
                next_rdata[7:0] = irq_mask;
            default:
                next_rdata = ZERO_WORD;
        endcase
    end

    // Read answer one cycle after the strobe; data holds until the next read
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {reg_rdata, reg_rd_valid} <= {ZERO_WORD, 1'b0};
        else if (clk_en)
        begin
            reg_rd_valid <= mgmt_req.rd;
            if (mgmt_req.rd)
                reg_rdata <= next_rdata;
        end
    end

endmodule
`default_nettype wire

/* test/phy_vendor_regs_props.sv */
// Purpose: Port checks for the vendor register bank
// Assumes: One clock; requests only while clk_en is high
// Notes: Energy timeout watched by a saturating counter
`default_nettype none
module phy_vendor_regs_props #(
    parameter int ENERGY_WINDOW = 32
) (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic soft_rst,
    // Register port
    input wire phy_vendor_pkg::mgmt_req_t mgmt_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_valid,
    // Status and configuration
    input wire logic [4:0] frame_phy_address,
    input wire logic phy_address_match,
    input wire logic line_energy,
    input wire phy_vendor_pkg::mode_cfg_t mode_cfg,
    input wire logic [2:0] op_mode,
    input wire logic [4:0] mgmt_phy_address,
    input wire logic energy_detect_powerdown_en,
    input wire logic energy_present,
    input wire logic rx_pll_force_reference,
    input wire logic phy_irq
);
    import phy_vendor_pkg::*;

    int quiet_cnt;
    logic rd_go;
    logic wr_go;

    // Qualified strobes; soft reset beats a write to the power-down bit or the mask
    assign rd_go = mgmt_req.rd && clk_en;
    assign wr_go = mgmt_req.wr && clk_en && !soft_rst;

    // Cycles of quiet line; margin covers the sync chain and filter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            quiet_cnt <= 0;
        else if (line_energy)
            quiet_cnt <= 0;
        else if (quiet_cnt < ENERGY_WINDOW + 16)
            quiet_cnt <= quiet_cnt + 1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_special_low_bits: assert property (rd_go && mgmt_req.index == IDX_SPECIAL_CTRL |=>
        reg_rd_valid && reg_rdata[3:0] == SPECIAL_LOW_BITS) else $error("special low bits wrong");
    a_mask_upper_zero: assert property (rd_go && mgmt_req.index == IDX_IRQ_MASK |=>
        reg_rd_valid && reg_rdata[15:8] == 8'h00) else $error("mask upper bits not zero");
    a_edpd_write: assert property (wr_go && mgmt_req.index == IDX_ENERGY_MODE |=>
        energy_detect_powerdown_en == $past(mgmt_req.wdata[EDPD_BIT])) else $error("power-down bit lost");
    a_soft_clears_edpd: assert property (soft_rst && clk_en |=> !energy_detect_powerdown_en)
        else $error("power-down kept over soft reset");
    a_pll_force_write: assert property (wr_go && mgmt_req.index == IDX_SPECIAL_CTRL |=>
        rx_pll_force_reference == $past(mgmt_req.wdata[PLL_FORCE_BIT])) else $error("pll force lost");
    a_strap_write: assert property (wr_go && mgmt_req.index == IDX_STRAP_MODE |=>
        mgmt_phy_address == $past(mgmt_req.wdata[4:0]) && op_mode == $past(mgmt_req.wdata[7:5]))
        else $error("mode or address lost");
    a_address_match: assert property (clk_en |=>
        phy_address_match == ($past(frame_phy_address) == $past(mgmt_phy_address))) else $error("match wrong");
    a_energy_timeout: assert property (quiet_cnt == ENERGY_WINDOW + 16 |-> !energy_present)
        else $error("energy present after quiet window");
    a_energy_hw_reset: assert property ($rose(rst_n) |-> energy_present)
        else $error("energy present low after reset");
    a_mode_ten_full: assert property (op_mode == MODE_10_FULL && clk_en |=>
        mode_cfg.ctrl_defaults == 4'h1 && !mode_cfg.autoneg_en) else $error("mode 001 defaults wrong");
    a_mode_all_capable: assert property (op_mode == MODE_ALL_CAPABLE && clk_en |=>
        mode_cfg.advert_defaults == 4'hF && mode_cfg.autoneg_en) else $error("mode 111 defaults wrong");
    a_repeater_crs: assert property (op_mode == MODE_REPEATER && clk_en |=>
        mode_cfg.repeater && !mode_cfg.crs_on_tx) else $error("repeater carrier sense wrong");

    c_irq_rise: cover property ($rose(phy_irq));
    c_energy_fall: cover property ($fell(energy_present));
    c_source_read: cover property (rd_go && mgmt_req.index == IDX_IRQ_SOURCE ##1 reg_rdata != 16'h0000);
endmodule

bind phy_vendor_regs phy_vendor_regs_props #(.ENERGY_WINDOW(ENERGY_WINDOW)) phy_vendor_regs_props_i (
    .sys_clk, .rst_n, .clk_en, .soft_rst, .mgmt_req, .reg_rdata, .reg_rd_valid, .frame_phy_address,
    .phy_address_match, .line_energy, .mode_cfg, .op_mode, .mgmt_phy_address, .energy_detect_powerdown_en,
    .energy_present, .rx_pll_force_reference, .phy_irq);
`default_nettype wire

/* test/mgmt_host_model.sv */
// Purpose: Station management host issuing word reads and writes
// Assumes: Strobes change at the falling edge and stand over one rising edge
// Notes: One idle cycle between requests keeps every strobe a clean pulse
`default_nettype none
module mgmt_host_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output var phy_vendor_pkg::mgmt_req_t mgmt_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_valid
);
    import phy_vendor_pkg::*;

    initial mgmt_req = '0;

    // Write one word; the reserved mode code is never sent
    task automatic write_reg(input logic [4:0] idx, input logic [15:0] data);
        if (idx == IDX_STRAP_MODE && data[7:5] == MODE_RESERVED)
            return;
        @(negedge sys_clk);
        mgmt_req = '{rd: 1'b0, wr: 1'b1, index: idx, wdata: data};
        @(negedge sys_clk);
        mgmt_req = '0;
    endtask

    // Read one word; valid stands for the single cycle after the strobe, the word until the next read
    task automatic read_reg(input logic [4:0] idx, output logic [15:0] data, output logic seen);
        @(negedge sys_clk);
        mgmt_req = '{rd: 1'b1, wr: 1'b0, index: idx, wdata: ZERO_WORD};
        @(negedge sys_clk);
        mgmt_req = '0;
        seen = reg_rd_valid;
        data = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the vendor registers
// Assumes: Energy window shortened to WIN cycles; clk_en held high
// Notes: Line energy starts low, so the quiet window expires early
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_vendor_pkg::*;
    localparam int WIN = 32;

    logic sys_clk, rst_n, clk_en, soft_rst, line_energy, line_polarity_reversed, link_status;
    logic reg_rd_valid, phy_address_match, edpd, energy_present, pll_force, phy_irq;
    logic [4:0] frame_phy_address, mgmt_phy_address;
    logic [2:0] mode_strap, op_mode;
    logic [15:0] reg_rdata;
    mgmt_req_t mgmt_req;
    an_events_t an_events;
    mode_cfg_t mode_cfg;
    int fail_count, checks;

    phy_vendor_regs #(.ENERGY_WINDOW(WIN)) phy_vendor_regs_i (.sys_clk, .rst_n, .clk_en, .soft_rst, .mgmt_req,
        .reg_rdata, .reg_rd_valid, .frame_phy_address, .phy_address_match, .mode_strap, .line_energy,
        .line_polarity_reversed, .link_status, .an_events, .mode_cfg, .op_mode, .mgmt_phy_address,
        .energy_detect_powerdown_en(edpd), .energy_present, .rx_pll_force_reference(pll_force), .phy_irq);

    mgmt_host_model mgmt_host_model_i (.sys_clk, .mgmt_req, .reg_rdata, .reg_rd_valid);

    // Clock at 200 MHz
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [4:0] idx, input logic [15:0] data);
        mgmt_host_model_i.write_reg(idx, data);
    endtask

    // Read through the host and compare
    task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        mgmt_host_model_i.read_reg(idx, d, v);
        `CHK("read valid", 1'b1, v)
        `CHK("read word", exp, d)
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Reset values, read-only and unmapped writes
    task automatic t_after_reset();
        rd_chk(IDX_ENERGY_MODE, 16'h0002);
        rd_chk(IDX_STRAP_MODE, 16'h0081);
        rd_chk(IDX_SPECIAL_CTRL, 16'h000B);
        rd_chk(IDX_IRQ_MASK, 16'h0000);
        wr(IDX_IRQ_SOURCE, 16'h00FE);
        rd_chk(IDX_IRQ_SOURCE, 16'h0000);
        wr(5'h05, 16'h1234);
        rd_chk(5'h05, 16'h0000);
        $display("test after_reset done");
    endtask

    // Quiet line drops the indicator, soft reset keeps it; energy flags bit 7
    task automatic t_energy();
        cyc(WIN + 12);
        `CHK("energy quiet", 1'b0, energy_present)
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        rd_chk(IDX_ENERGY_MODE, 16'h0000);
        wr(IDX_IRQ_MASK, 16'h0080);
        line_energy = 1'b1;
        cyc(10);
        `CHK("energy back", 1'b1, energy_present)
        `CHK("energy irq", 1'b1, phy_irq)
        rd_chk(IDX_IRQ_SOURCE, 16'h0080);
        cyc(1);
        `CHK("irq after read", 1'b0, phy_irq)
        $display("test energy done");
    endtask

    // Every auto-negotiation event source, link loss, then a masked source
    task automatic t_events();
        int fl [5] = '{1, 2, 3, 5, 6};
        wr(IDX_IRQ_MASK, 16'h00FF);
        for (int j = 0; j < 5; j++)
        begin
            an_events = an_events_t'(5'b00001 << j);
            cyc(1);
            an_events = '0;
            cyc(1);
            `CHK("irq set", 1'b1, phy_irq)
            rd_chk(IDX_IRQ_SOURCE, 16'h0001 << fl[j]);
            cyc(1);
            `CHK("irq cleared", 1'b0, phy_irq)
        end
        link_status = 1'b0;
        cyc(2);
        rd_chk(IDX_IRQ_SOURCE, 16'h0010);
        link_status = 1'b1;
        wr(IDX_IRQ_MASK, 16'h0040);
        an_events.remote_fault = 1'b1;
        cyc(1);
        an_events = '0;
        cyc(2);
        `CHK("masked irq", 1'b0, phy_irq)
        rd_chk(IDX_IRQ_SOURCE, 16'h0020);
        $display("test events done");
    endtask

    // Every legal mode code and the defaults it hands on
    task automatic t_modes();
        logic [3:0] ctrl [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hC, 4'h0, 4'h4};
        for (int m = 0; m < 8; m++)
        begin
            if (m == 6)
                continue;
            wr(IDX_STRAP_MODE, {8'h00, 3'(m), 5'h01});
            cyc(2);
            `CHK("op mode", 3'(m), op_mode)
            `CHK("ctrl defaults", ctrl[m], mode_cfg.ctrl_defaults)
            `CHK("autoneg", m > 3, mode_cfg.autoneg_en)
            `CHK("crs on tx", m == 2 || m == 4, mode_cfg.crs_on_tx)
            `CHK("repeater", m == 5, mode_cfg.repeater)
            `CHK("duplex", m == 1 || m == 3 || m == 7, mode_cfg.full_duplex)
            if (m > 3)
                `CHK("advert", m == 7 ? 4'hF : 4'h4, mode_cfg.advert_defaults)
        end
        $display("test modes done");
    endtask

    // Writable fields, polarity, address match, soft reset
    task automatic t_soft();
        line_polarity_reversed = 1'b1;
        frame_phy_address = 5'h0A;
        wr(IDX_ENERGY_MODE, 16'h2000);
        wr(IDX_IRQ_MASK, 16'h00FF);
        wr(IDX_SPECIAL_CTRL, 16'h0400);
        wr(IDX_STRAP_MODE, 16'h00EA);
        cyc(2);
        `CHK("powerdown", 1'b1, edpd)
        `CHK("pll force", 1'b1, pll_force)
        `CHK("addr match", 1'b1, phy_address_match)
        rd_chk(IDX_ENERGY_MODE, 16'h2002);
        rd_chk(IDX_IRQ_MASK, 16'h00FF);
        rd_chk(IDX_SPECIAL_CTRL, 16'h041B);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        cyc(1);
        rd_chk(IDX_ENERGY_MODE, 16'h0002);
        rd_chk(IDX_IRQ_MASK, 16'h0000);
        rd_chk(IDX_SPECIAL_CTRL, 16'h041B);
        rd_chk(IDX_STRAP_MODE, 16'h00EA);
        $display("test soft_reset done");
    endtask

    // Main sequence; every input has a value at time zero
    initial
    begin
        {rst_n, soft_rst, line_energy, line_polarity_reversed, fail_count, checks} = '0;
        {clk_en, link_status} = 2'b11;
        mode_strap = MODE_AN_100_HALF;
        frame_phy_address = 5'h00;
        an_events = '0;
        cyc(6);
        rst_n = 1'b1;
        cyc(2);
        t_after_reset();
        t_energy();
        t_events();
        t_modes();
        t_soft();
        test_done();
    end

    // Watchdog far beyond the test length
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        $display("watchdog expired");
        test_done();
    end
endmodule
`default_nettype wire
